// file: inc/hvps_pkg.sv
// Constants for the high-voltage pin protection and status block.
// Assumes a single 40 MHz system clock and the indirect command/data pair.
package hvps_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int  CLK_HZ        = 40_000_000;   // System clock rate
  localparam int  HZ_PER_MHZ    = 1_000_000;    // Unit conversion
  localparam int  LIN_SHORT_US  = 20;           // LIN short must outlast
  localparam int  WAKE_SHORT_US = 400;          // Wake short must outlast
  localparam real WAKE_TOUT_S   = 1.3;          // Wake auto-deassert time
  // "Longer than" the time: one cycle beyond the exact count
  localparam int  LIN_FILT_CYC  =
    LIN_SHORT_US * (CLK_HZ / HZ_PER_MHZ) + 1;
  localparam int  WAKE_FILT_CYC =
    WAKE_SHORT_US * (CLK_HZ / HZ_PER_MHZ) + 1;
  localparam int  WAKE_TOUT_CYC = int'(WAKE_TOUT_S * real'(CLK_HZ));
  localparam int  FILT_W        = 15;           // Holds 16001
  localparam int  TOUT_W        = 26;           // Holds 52 million

  // ---------------------------------------------------------------
  // Command port and register indices
  // ---------------------------------------------------------------
  localparam int       CMD_WR_BIT = 7;          // 1 = write command
  localparam logic [1:0] IDX_BASE = 2'h0;       // hv_base_config
  localparam logic [1:0] IDX_IO   = 2'h1;       // high_voltage_pins_config
  localparam logic [1:0] IDX_STA  = 2'h2;       // hv_irq_status
  localparam logic [1:0] IDX_MON  = 2'h3;       // hv_monitor_reg
  localparam logic [7:0] BASE_RST = 8'h00;      // Reset values
  localparam logic [7:0] IO_RST   = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int  BASE_LIN_LO  = 0;             // LIN mode, two bits
  localparam int  BASE_LIN_HI  = 1;
  localparam int  BASE_LVF_EN  = 2;             // Low voltage flag enable
  localparam int  BASE_PSM_EN  = 3;             // Supply monitor enable
  localparam int  BASE_WAKE_AS = 4;             // Wake assert
  localparam int  BASE_THERM_K = 7;             // 1 = no thermal shutdown
  localparam logic [1:0] LIN_MODE_ON = 2'h2;    // LIN enabled code
  localparam int  IO_PULLUP    = 0;             // Open-circuit pull-up
  localparam int  IO_TOUT_DIS  = 1;             // Timeout counter off
  localparam int  IO_LIN_PASS  = 2;             // Passive LIN protection
  localparam int  IO_REEN      = 3;             // Re-enable pins
  localparam int  IO_RB_EN     = 4;             // Wake read-back enable
  localparam int  IO_VCH_SHORT = 5;             // Voltage channel short
  localparam int  IO_TMON      = 6;             // Temperature monitor
  localparam int  IO_ATTEN     = 7;             // Attenuator and buffer
  localparam int  STA_WSC      = 0;             // Status: wake short
  localparam int  STA_LIN      = 2;             // Status: LIN short
  localparam int  STA_TEMP     = 3;             // Status: over-temp
  localparam int  STA_WAKE     = 4;             // Status: wake edge
  localparam int  STA_PSM      = 5;             // Status: supply low
  localparam int  MON_WSC      = 0;             // Monitor fields
  localparam int  MON_LIN      = 2;
  localparam int  MON_LVF      = 3;
  localparam int  MON_BUF      = 4;
  localparam int  MON_TEMP     = 6;
  localparam int  MON_WAKE     = 7;

endpackage : hvps_pkg

// file: hdl/hvps_timer.sv
// Persistence / timeout counter: fires one pulse after run stays high.
// Assumes run is synchronous to clock; limit is held stable while run.
`timescale 1ns/100ps

module hvps_timer #(
  parameter int W = 16                  // Counter width
) (
  input  wire logic         clock,      // System clock
  input  wire logic         reset_n,    // Synchronous reset, active low
  input  wire logic         run,        // Condition being timed
  input  wire logic [W-1:0] limit,      // Cycles of run before firing
  output logic              done        // One-cycle pulse, registered
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] count;                // Cycles of run seen
    logic         fired;                // Fired once this run
    logic         done;                 // Output pulse
  } hvps_tmr_type;

  hvps_tmr_type st_reg;                 // Registered state
  hvps_tmr_type st_next;                // Next state

  // Count while run; restart whenever run drops
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (!run) begin
      st_next.count = '0;
      st_next.fired = 1'b0;
    end else if (!st_reg.fired) begin
      if (st_reg.count == limit - W'(1)) begin
        st_next.fired = 1'b1;           // Fire once, no re-arm in run
        st_next.done  = 1'b1;
      end else begin
        st_next.count = st_reg.count + W'(1);
      end
    end
  end

  // Register the state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done = st_reg.done;

endmodule : hvps_timer

// file: hdl/hvps_top.sv
// High-voltage pin protection, configuration and interrupt status.
// Assumes pin-side inputs are synchronous to clock and the processor
// interrupt enable bit arrives as a plain level.
//
// How it works
// - Read-back enable accepts wake input, edges interrupt
// - Monitor bit 7 shows wake level when enabled
// - Writing IO enable re-enables shorted pins
// - Shorts count only past 20us/400us persistence
// - IO enable also clears thermal wake disable
// - IO enable write clears pending short interrupt
// - Passive LIN mode: flag, interrupt, driver stays
// - Active LIN mode: flag, interrupt, driver off
// - Interrupt source gated by enable bit 16
// - Wake auto-deasserts 1.3s unless timeout disabled
// - Bit 0 drives open-circuit pull-up
// - Clearing short enable removes voltage short
// - Status register read-only, resets to zero
// - Interrupt copies status into data port
// - Status bit 5 unlatched supply low
// - Status bit 4 set by wake edge
// - Status bit 3 set by thermal event
// - Status bit 2 set by LIN short
// - Status bit 0 set by wake short
// - Wake assert bit drives pin high
// - IO enable write clears monitor LIN flag
// - Supply monitor interrupts on low supply
`timescale 1ns/100ps

module hvps_top #(
  parameter int LIN_FILT  = hvps_pkg::LIN_FILT_CYC,   // LIN persistence
  parameter int WAKE_FILT = hvps_pkg::WAKE_FILT_CYC,  // Wake persistence
  parameter int WAKE_TOUT = hvps_pkg::WAKE_TOUT_CYC   // Wake timeout
) (
  input  wire logic       clock,            // 40 MHz system clock
  input  wire logic       reset_n,          // Sync reset, active low
  input  wire logic       cmd_wr,           // Command strobe
  input  wire logic [7:0] cmd_code,         // Bit 7 write, 1:0 index
  input  wire logic       data_wr,          // Data port write strobe
  input  wire logic [7:0] data_wdata,       // Data port write value
  output logic      [7:0] data_rdata,       // Data port contents
  input  wire logic       irq_enable_bit,   // Enable bit for source 3
  output logic            hv_irq_source,    // Interrupt request
  input  wire logic       wake_pin_in,      // Wake pin level
  output logic            wake_pin_out,     // Wake drive value
  output logic            wake_pin_oe,      // Wake drive enable
  output logic            wake_pulldown_en, // Internal pull-down
  output logic            wake_pullup_en,   // Diagnostic pull-up
  output logic            wake_input_en,    // Wake input buffer on
  input  wire logic       lin_short_in,     // LIN short sensed
  input  wire logic       wake_short_in,    // Wake short sensed
  input  wire logic       thermal_in,       // Thermal shutdown sensed
  input  wire logic       supply_low_in,    // Supply below 6.0V
  input  wire logic       low_volt_in,      // Low voltage flag level
  input  wire logic       vbuf_on_in,       // Voltage buffer running
  output logic            lin_drv_en,       // LIN driver enable
  output logic            vch_short_en,     // Voltage channel short
  output logic            atten_en,         // Attenuator enable
  output logic            hv_temp_mon_en,   // HV temperature monitor
  output logic            supply_mon_en     // Supply monitor enable
);

  // ---------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] base;        // hv_base_config
    logic [7:0] io;          // high_voltage_pins_config
    logic [7:0] data;        // hv_data_port
    logic       st_wake;     // Wake edge seen
    logic       st_temp;     // Thermal event seen
    logic       st_lin;      // LIN short seen
    logic       st_wsc;      // Wake short seen
    logic       lin_off;     // LIN driver forced off
    logic       wake_off;    // Wake driver forced off
    logic       wake_prev;   // Last wake level
    logic       temp_prev;   // Last thermal level
    logic       psm_prev;    // Last qualified supply-low level
    logic       irq;         // Interrupt output
    logic       w_out;       // Wake pin outputs
    logic       w_oe;
    logic       w_pd;
    logic       w_pu;
    logic       w_in;
    logic       lin_en;      // Driver and analog enables
    logic       vsh;
    logic       att;
    logic       tmon;
    logic       supply_monitor;
  } hvps_state_type;

  localparam hvps_state_type RST_STATE = '{
    base: hvps_pkg::BASE_RST,
    io:   hvps_pkg::IO_RST,
    data: hvps_pkg::DATA_RST,
    w_pd: 1'b1,
    default: '0
  };

  hvps_state_type st_reg;    // Registered state
  hvps_state_type st_next;   // Next state

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic [1:0] cmd_idx;       // Register selected by command
  logic       cmd_write;     // Write command this cycle
  logic       sta_rd;        // Status read this cycle
  logic       reen;          // Re-enable action
  logic       psm_low;       // Supply low while monitor enabled
  logic       wake_edge;     // Qualified wake transition
  logic       temp_rise;     // New thermal event
  logic       psm_rise;      // New supply-low event
  logic       lin_fire;      // LIN short outlasted filter
  logic       wsc_fire;      // Wake short outlasted filter
  logic       tout_fire;     // Wake timeout elapsed
  logic       irq_evt;       // Any new interrupt event
  logic [7:0] mon_view;      // Monitor register image

  // Status image; reserved bits read as zero
  function automatic logic [7:0] sta_pack(
    input hvps_state_type s,
    input logic           supply_monitor
  );
    logic [7:0] v;
    v                     = '0;
    v[hvps_pkg::STA_PSM]  = supply_monitor;        // Unlatched
    v[hvps_pkg::STA_WAKE] = s.st_wake;
    v[hvps_pkg::STA_TEMP] = s.st_temp;
    v[hvps_pkg::STA_LIN]  = s.st_lin;
    v[hvps_pkg::STA_WSC]  = s.st_wsc;
    return v;
  endfunction : sta_pack

  assign cmd_idx   = cmd_code[1:0];
  assign cmd_write = cmd_wr & cmd_code[hvps_pkg::CMD_WR_BIT];
  assign sta_rd    = cmd_wr & ~cmd_code[hvps_pkg::CMD_WR_BIT]
                     & (cmd_idx == hvps_pkg::IDX_STA);
  // Action comes from the value written, held in the data port
  assign reen      = cmd_write & (cmd_idx == hvps_pkg::IDX_IO)
                     & st_reg.data[hvps_pkg::IO_REEN];
  assign psm_low   = supply_low_in
                     & st_reg.base[hvps_pkg::BASE_PSM_EN];
  assign wake_edge = st_reg.io[hvps_pkg::IO_RB_EN]
                     & (wake_pin_in != st_reg.wake_prev);
  assign temp_rise = thermal_in & ~st_reg.temp_prev;
  assign psm_rise  = psm_low & ~st_reg.psm_prev;
  assign irq_evt   = wake_edge | temp_rise | psm_rise
                     | lin_fire | wsc_fire;

  // Monitor image: live wake level only when read-back is on
  always_comb begin
    mon_view                     = '0;
    mon_view[hvps_pkg::MON_WAKE] = wake_pin_in
                                   & st_reg.io[hvps_pkg::IO_RB_EN];
    mon_view[hvps_pkg::MON_TEMP] = st_reg.st_temp;
    mon_view[hvps_pkg::MON_BUF]  = vbuf_on_in;
    mon_view[hvps_pkg::MON_LVF]  = low_volt_in
                                   & st_reg.base[hvps_pkg::BASE_LVF_EN];
    mon_view[hvps_pkg::MON_LIN]  = st_reg.st_lin;
    mon_view[hvps_pkg::MON_WSC]  = st_reg.st_wsc;
  end

  // ---------------------------------------------------------------
  // Filters and timeout
  // ---------------------------------------------------------------
  // LIN short persistence
  hvps_timer #(.W(hvps_pkg::FILT_W)) u_lin_filt (
    .clock   (clock),
    .reset_n (reset_n),
    .run     (lin_short_in),
    .limit   (hvps_pkg::FILT_W'(LIN_FILT)),
    .done    (lin_fire)
  );

  // Wake short persistence
  hvps_timer #(.W(hvps_pkg::FILT_W)) u_wake_filt (
    .clock   (clock),
    .reset_n (reset_n),
    .run     (wake_short_in),
    .limit   (hvps_pkg::FILT_W'(WAKE_FILT)),
    .done    (wsc_fire)
  );

  // Wake timeout runs only while asserted and not disabled
  hvps_timer #(.W(hvps_pkg::TOUT_W)) u_wake_tout (
    .clock   (clock),
    .reset_n (reset_n),
    .run     (st_reg.base[hvps_pkg::BASE_WAKE_AS]
              & ~st_reg.io[hvps_pkg::IO_TOUT_DIS]),
    .limit   (hvps_pkg::TOUT_W'(WAKE_TOUT)),
    .done    (tout_fire)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // Command port; a data write in a command cycle is dropped
    if (cmd_wr) begin
      if (cmd_code[hvps_pkg::CMD_WR_BIT]) begin
        if (cmd_idx == hvps_pkg::IDX_BASE) begin
          st_next.base = st_reg.data;
        end else if (cmd_idx == hvps_pkg::IDX_IO) begin
          st_next.io = st_reg.data;
        end
        // Status and monitor ignore writes
      end else begin
        unique case (cmd_idx)
          hvps_pkg::IDX_BASE: st_next.data = st_reg.base;
          hvps_pkg::IDX_IO:   st_next.data = st_reg.io;
          hvps_pkg::IDX_STA:  st_next.data = sta_pack(st_reg, psm_low);
          hvps_pkg::IDX_MON:  st_next.data = mon_view;
        endcase
      end
    end else if (data_wr) begin
      st_next.data = data_wdata;
    end
    // Clears first, so that a set in the same cycle wins
    if (sta_rd) begin
      st_next.st_wake = 1'b0;
      st_next.st_temp = 1'b0;
    end
    if (reen) begin
      st_next.st_lin   = 1'b0;
      st_next.st_wsc   = 1'b0;
      st_next.lin_off  = 1'b0;
      st_next.wake_off = 1'b0;
    end
    if (wake_edge) begin
      st_next.st_wake = 1'b1;
    end
    if (temp_rise) begin
      st_next.st_temp = 1'b1;
      if (!st_reg.base[hvps_pkg::BASE_THERM_K]) begin
        st_next.wake_off = 1'b1;
      end
    end
    if (lin_fire) begin
      st_next.st_lin = 1'b1;
      // Passive mode keeps the driver on
      if (!st_reg.io[hvps_pkg::IO_LIN_PASS]) begin
        st_next.lin_off = 1'b1;
      end
    end
    if (wsc_fire) begin
      st_next.st_wsc   = 1'b1;
      st_next.wake_off = 1'b1;
    end
    // Timeout beats a same-cycle software write of the assert bit
    if (tout_fire) begin
      st_next.base[hvps_pkg::BASE_WAKE_AS] = 1'b0;
    end
    st_next.wake_prev = wake_pin_in;
    st_next.temp_prev = thermal_in;
    st_next.psm_prev  = psm_low;
    // Snapshot of the updated status on any event
    if (irq_evt) begin
      st_next.data = sta_pack(st_next, psm_low);
    end
    // Level interrupt while any status bit stands
    st_next.irq  = irq_enable_bit & (|sta_pack(st_next, psm_low));
    // Pin and analog controls from the updated configuration
    st_next.w_oe   = st_next.base[hvps_pkg::BASE_WAKE_AS]
                     & ~st_next.wake_off;
    st_next.w_out  = st_next.w_oe;
    st_next.w_pd   = ~st_next.w_oe;
    st_next.w_pu   = st_next.io[hvps_pkg::IO_PULLUP];
    st_next.w_in   = st_next.io[hvps_pkg::IO_RB_EN];
    st_next.lin_en = (st_next.base[hvps_pkg::BASE_LIN_HI:
                                   hvps_pkg::BASE_LIN_LO]
                      == hvps_pkg::LIN_MODE_ON)
                     & ~st_next.lin_off;
    st_next.vsh    = st_next.io[hvps_pkg::IO_VCH_SHORT];
    st_next.att    = st_next.io[hvps_pkg::IO_ATTEN];
    st_next.tmon   = st_next.io[hvps_pkg::IO_TMON];
    st_next.supply_monitor    = st_next.base[hvps_pkg::BASE_PSM_EN];
  end

  // Register the state
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_reg <= RST_STATE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from the state flops
  // ---------------------------------------------------------------
  assign data_rdata       = st_reg.data;
  assign hv_irq_source    = st_reg.irq;
  assign wake_pin_out     = st_reg.w_out;
  assign wake_pin_oe      = st_reg.w_oe;
  assign wake_pulldown_en = st_reg.w_pd;
  assign wake_pullup_en   = st_reg.w_pu;
  assign wake_input_en    = st_reg.w_in;
  assign lin_drv_en       = st_reg.lin_en;
  assign vch_short_en     = st_reg.vsh;
  assign atten_en         = st_reg.att;
  assign hv_temp_mon_en   = st_reg.tmon;
  assign supply_mon_en    = st_reg.supply_monitor;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [15:0] lin_hi_cnt;  // Consecutive LIN short cycles, saturating

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      lin_hi_cnt <= '0;
    end else if (!lin_short_in) begin
      lin_hi_cnt <= '0;
    end else if (lin_hi_cnt != '1) begin
      lin_hi_cnt <= lin_hi_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_mon_read;
    cmd_wr && !cmd_code[hvps_pkg::CMD_WR_BIT]
      && cmd_idx == hvps_pkg::IDX_MON && !irq_evt;
  endsequence

  sequence s_reen_quiet;
    reen && !lin_fire && !wsc_fire && !temp_rise;
  endsequence

  sequence s_lin_active;
    lin_fire && !st_reg.io[hvps_pkg::IO_LIN_PASS];
  endsequence

  AST_WAKE_EDGE: assert property (wake_edge |=> st_reg.st_wake ##0
      hv_irq_source == $past(irq_enable_bit))
    else $error("wake edge did not flag");
  AST_MON_WAKE: assert property (s_mon_read |=>
      data_rdata[hvps_pkg::MON_WAKE] == $past(wake_pin_in
        && st_reg.io[hvps_pkg::IO_RB_EN]))
    else $error("monitor wake level wrong");
  AST_REEN: assert property (s_reen_quiet |=>
      !st_reg.lin_off && !st_reg.wake_off && !st_reg.st_lin)
    else $error("re-enable did not clear");
  AST_LIN_FILT: assert property (lin_fire |->
      int'(lin_hi_cnt) >= LIN_FILT)
    else $error("LIN short fired too early");
  AST_PASSIVE: assert property (lin_fire
      && st_reg.io[hvps_pkg::IO_LIN_PASS] && !reen |=>
      st_reg.st_lin && st_reg.lin_off == $past(st_reg.lin_off))
    else $error("passive mode disabled driver");
  AST_ACTIVE: assert property (s_lin_active |=>
      !lin_drv_en && st_reg.st_lin ##1 (!lin_drv_en || $past(reen)))
    else $error("active mode left driver on");
  AST_IRQ_GATE: assert property (!irq_enable_bit |=>
      !hv_irq_source)
    else $error("interrupt not gated");
  AST_TOUT: assert property (tout_fire |=>
      !st_reg.base[hvps_pkg::BASE_WAKE_AS] && !wake_pin_oe)
    else $error("wake timeout missed");
  AST_SNAPSHOT: assert property (irq_evt |=>
      data_rdata == sta_pack(st_reg, $past(psm_low)))
    else $error("status not copied to data port");

endmodule : hvps_top

// file: bench/hvps_pins.sv
// Model of the wake pin wiring outside the protection block.
// Assumes the bench steers the outside load and the short sensors.
`timescale 1ns/100ps

module hvps_pins (
  input  wire logic oe,     // Block drives the wake pin
  input  wire logic out,    // Drive value
  input  wire logic pu,     // Diagnostic pull-up
  input  wire logic pd,     // Internal pull-down
  input  wire logic ext_en, // Outside load shorts pin low
  output logic      pin     // Resolved wake level
);
  // Driver wins, then the outside load, then the pulls
  always_comb begin
    if (oe)
      pin = out;
    else if (ext_en)
      pin = 1'b0;
    else if (pu)
      pin = 1'b1;
    else
      pin = ~pd;  // Pulled-down pin reads low, an unpulled one high
  end
endmodule : hvps_pins

// file: bench/testbench.sv
// Self-checking bench for the pin protection and status block.
// Assumes shortened filter and timeout counts set by parameter.
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  mismatches++; $display("MISMATCH %0t %h %h", $time, a, e); end end

module testbench;
  logic       clock = 0, reset_n = 0, cmd_wr = 0, data_wr = 0;
  logic [7:0] cmd_code = 0, data_wdata = 0, data_rdata, rd;
  logic       irq_enable_bit = 1, hv_irq_source, pin, oe, wout, pd, pu;
  logic       lin_short_in = 0, wake_short_in = 0, thermal_in = 0;
  logic       supply_low_in = 0, ext_en = 0, inen, lin_drv_en;
  logic       vch_short_en, supply_mon_en, atten_en, hv_temp_mon_en;
  int         mismatches = 0, checks_done = 0, cycles = 0;

  always #12.5 clock = ~clock; // 40 MHz

  hvps_top #(.LIN_FILT(5), .WAKE_FILT(9), .WAKE_TOUT(20)) DUT (
    .clock, .reset_n, .cmd_wr, .cmd_code, .data_wr, .data_wdata,
    .data_rdata, .irq_enable_bit, .hv_irq_source, .wake_pin_in(pin),
    .wake_pin_out(wout), .wake_pin_oe(oe), .wake_pulldown_en(pd),
    .wake_pullup_en(pu), .wake_input_en(inen), .lin_short_in,
    .wake_short_in, .thermal_in, .supply_low_in, .low_volt_in(1'b0),
    .vbuf_on_in(1'b0), .lin_drv_en, .vch_short_en, .atten_en,
    .hv_temp_mon_en, .supply_mon_en);

  hvps_pins PINS (.oe, .out(wout), .pu, .pd, .ext_en, .pin);

  // Inputs always change 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // Load data port, then issue the write command
  task automatic wr(input logic [1:0] idx, input logic [7:0] v);
    data_wr = 1;
    data_wdata = v;
    tick(1);
    data_wr = 0;
    cmd_wr = 1;
    cmd_code = {6'h20, idx};
    tick(1);
    cmd_wr = 0;
    tick(1);
  endtask : wr

  // Read command; result shows in the data port one cycle later
  task automatic rdr(input logic [1:0] idx);
    cmd_wr = 1;
    cmd_code = {6'h00, idx};
    tick(1);
    cmd_wr = 0;
    rd = data_rdata;
  endtask : rdr

  task automatic test_done;
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // Hang guard: far above the 160 or so cycles needed
  always @(posedge clock) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      test_done();
    end
  end

  initial begin
    tick(20);
    reset_n = 1;
    wr(2'h2, 8'h3d);
    `CHK(data_rdata, 8'h3d)
    wr(2'h1, 8'h01);
    wr(2'h1, 8'h11);
    `CHK({pu, inen}, 2'b11)
    rdr(2'h3);
    `CHK(rd[7], 1'b1)
    ext_en = 1; // Falling edge on the wake pin
    tick(4);
    `CHK({hv_irq_source, data_rdata}, 9'h110)
    rdr(2'h2);
    `CHK(rd, 8'h10)
    tick(1);
    rdr(2'h3);
    `CHK({hv_irq_source, rd}, 9'h000)
    wr(2'h1, 8'h00);
    wr(2'h0, 8'h02);
    lin_short_in = 1; // Too short to count
    tick(4);
    lin_short_in = 0;
    tick(4);
    `CHK({hv_irq_source, lin_drv_en}, 2'b01)
    lin_short_in = 1;
    tick(10);
    lin_short_in = 0;
    `CHK({hv_irq_source, lin_drv_en, data_rdata}, 10'h204)
    irq_enable_bit = 0;
    tick(2);
    `CHK(hv_irq_source, 1'b0)
    irq_enable_bit = 1;
    wr(2'h1, 8'h08);
    `CHK({hv_irq_source, lin_drv_en}, 2'b01)
    rdr(2'h3);
    `CHK(rd[2], 1'b0)
    wr(2'h1, 8'h04); // Passive protection
    lin_short_in = 1;
    tick(10);
    lin_short_in = 0;
    `CHK({hv_irq_source, lin_drv_en, data_rdata}, 10'h304)
    wr(2'h1, 8'h08);
    wake_short_in = 1;
    tick(14);
    wake_short_in = 0;
    `CHK(data_rdata, 8'h01)
    wr(2'h1, 8'h0a);
    wr(2'h0, 8'h12);
    `CHK({oe, wout}, 2'b11)
    thermal_in = 1;
    tick(4);
    `CHK({oe, data_rdata}, 9'h008)
    wr(2'h1, 8'h0a);
    `CHK(oe, 1'b1)
    rdr(2'h2);
    `CHK(rd, 8'h08)
    thermal_in = 0;
    wr(2'h1, 8'h00); // Timeout counter now runs
    tick(10);
    `CHK(oe, 1'b1)
    tick(20);
    `CHK({oe, pd}, 2'b01)
    wr(2'h0, 8'h08);
    supply_low_in = 1;
    tick(3);
    `CHK({supply_mon_en, hv_irq_source}, 2'b11)
    rdr(2'h2);
    `CHK(rd, 8'h20)
    supply_low_in = 0;
    tick(2);
    `CHK(hv_irq_source, 1'b0)
    wr(2'h1, 8'he0);
    `CHK({vch_short_en, atten_en, hv_temp_mon_en}, 3'b111)
    wr(2'h1, 8'h00);
    `CHK({vch_short_en, atten_en, hv_temp_mon_en}, 3'b000)
    test_done();
  end
endmodule : testbench
